/* File: core/ipb_pkg.sv */
package ipb_pkg;
	// widths of the bank
	localparam int             NUM_SOURCES = 16;
	localparam int             REG_W       = 16;
	localparam int             LEVEL_W     = 3;

	// one 3-bit priority level; 0 means the source is switched off
	typedef logic [2:0] ipb_level_type;

	// interrupt sources served by this bank, in output order
	typedef enum {
		SRC_SERIAL2_TX, SRC_SERIAL2_RX, SRC_EXT_IRQ2, SRC_TIMER5,
		SRC_CAN_EVENT, SRC_CAN_RECEIVE, SRC_SPI2_EVENT, SRC_SPI2_ERROR,
		SRC_DMA3_DONE, SRC_DMA4_DONE, SRC_PARALLEL_PORT, SRC_ENCODER1,
		SRC_PULSE_GEN1, SRC_PULSE_FAULT_A, SRC_CALENDAR, SRC_DMA5_DONE
	} ipb_source_type;

	// register indices
	localparam logic [2:0]     REG_SERIAL2_TIMER5 = 3'h0;
	localparam logic [2:0]     REG_CAN_SPI2       = 3'h1;
	localparam logic [2:0]     REG_DMA3           = 3'h2;
	localparam logic [2:0]     REG_DMA4_PARPORT   = 3'h3;
	localparam logic [2:0]     REG_ENCODER_PWM    = 3'h4;
	localparam logic [2:0]     REG_FAULT_RTC_DMA5 = 3'h5;
	localparam logic [2:0]     REG_ACTIVE_STATUS  = 3'h6;

	// byte offsets on the bus, one aligned word per register
	localparam logic [7:0]     OFS_SERIAL2_TIMER5 = 8'h00;
	localparam logic [7:0]     OFS_CAN_SPI2       = 8'h04;
	localparam logic [7:0]     OFS_DMA3           = 8'h08;
	localparam logic [7:0]     OFS_DMA4_PARPORT   = 8'h0C;
	localparam logic [7:0]     OFS_ENCODER_PWM    = 8'h10;
	localparam logic [7:0]     OFS_FAULT_RTC_DMA5 = 8'h14;
	localparam logic [7:0]     OFS_ACTIVE_STATUS  = 8'h18;

	// low bit of each field slot inside a register
	localparam logic [3:0]     POS_TOP    = 4'hC;
	localparam logic [3:0]     POS_UPPER  = 4'h8;
	localparam logic [3:0]     POS_LOWER  = 4'h4;
	localparam logic [3:0]     POS_BOTTOM = 4'h0;

	// level 4 after power-on, level 0 disables
	localparam ipb_level_type  FIELD_RESET = 3'h4;
	localparam ipb_level_type  LEVEL_OFF   = 3'h0;

	// which register and which slot each source lives in
	localparam logic [2:0] SRC_REG [NUM_SOURCES] = '{
		REG_SERIAL2_TIMER5, REG_SERIAL2_TIMER5, REG_SERIAL2_TIMER5,
		REG_SERIAL2_TIMER5, REG_CAN_SPI2, REG_CAN_SPI2, REG_CAN_SPI2,
		REG_CAN_SPI2, REG_DMA3, REG_DMA4_PARPORT, REG_DMA4_PARPORT,
		REG_ENCODER_PWM, REG_ENCODER_PWM, REG_FAULT_RTC_DMA5,
		REG_FAULT_RTC_DMA5, REG_FAULT_RTC_DMA5};
	localparam logic [3:0] SRC_POS [NUM_SOURCES] = '{
		POS_TOP, POS_UPPER, POS_LOWER, POS_BOTTOM,
		POS_TOP, POS_UPPER, POS_LOWER, POS_BOTTOM,
		POS_BOTTOM, POS_UPPER, POS_LOWER,
		POS_UPPER, POS_LOWER,
		POS_TOP, POS_UPPER, POS_LOWER};
endpackage

/* File: core/ipb_regbus_if.sv */
// register access between the bus slave and the priority bank
interface ipb_regbus_if;
	import ipb_pkg::*;
	logic              wrStrobe;  // one-cycle write, taken at this edge
	logic [2:0]        regIndex;  // register addressed
	logic [REG_W-1:0]  wrData;    // write data, low half of the bus word
	logic [1:0]        wrLanes;   // byte lanes 1 and 0 of the write
	logic [REG_W-1:0]  rdData;    // image of the addressed register

	modport slave (output wrStrobe, output regIndex, output wrData,
		output wrLanes, input rdData);
	modport bank (input wrStrobe, input regIndex, input wrData,
		input wrLanes, output rdData);
endinterface

/* File: core/ipb_wb_slave.sv */
// classic wishbone slave: one registered ack per request
module ipb_wb_slave
	import ipb_pkg::*;
(
	input  wire logic         core_clk,
	input  wire logic         rst,
	input  wire logic         wb_cyc_i,
	input  wire logic         wb_stb_i,
	input  wire logic         wb_we_i,
	input  wire logic [7:0]   wb_adr_i,
	input  wire logic [3:0]   wb_sel_i,
	input  wire logic [31:0]  wb_dat_i,
	output logic [31:0]       wb_dat_o,
	output logic              wb_ack_o,
	ipb_regbus_if.slave       regBus
);
	logic        request;   // live request not yet answered
	logic        mapped;    // address hits a register
	logic [2:0]  decIndex;  // decoded register index

	// address decode; anything else is unmapped and reads zero
	always_comb
	begin
		mapped = 1'b1;
		case (wb_adr_i)
			OFS_SERIAL2_TIMER5: decIndex = REG_SERIAL2_TIMER5;
			OFS_CAN_SPI2:       decIndex = REG_CAN_SPI2;
			OFS_DMA3:           decIndex = REG_DMA3;
			OFS_DMA4_PARPORT:   decIndex = REG_DMA4_PARPORT;
			OFS_ENCODER_PWM:    decIndex = REG_ENCODER_PWM;
			OFS_FAULT_RTC_DMA5: decIndex = REG_FAULT_RTC_DMA5;
			OFS_ACTIVE_STATUS:  decIndex = REG_ACTIVE_STATUS;
			default:
			begin
				decIndex = REG_SERIAL2_TIMER5;
				mapped   = 1'b0;
			end
		endcase
	end

	assign request          = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign regBus.regIndex  = decIndex;
	assign regBus.wrData    = wb_dat_i[REG_W-1:0];
	assign regBus.wrLanes   = wb_sel_i[1:0];
	// write lands on the edge where the master sees ack
	assign regBus.wrStrobe  = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o
		& mapped;

	// ack one cycle after the request, dropped the cycle after
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= request;
	end

	// read data captured with the ack, upper half always zero
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			wb_dat_o <= 32'h0000_0000;
		else if (request && !wb_we_i && mapped)
			wb_dat_o <= {16'h0000, regBus.rdData};
		else if (request)
			wb_dat_o <= 32'h0000_0000;
	end
endmodule

/* File: core/ipb_priority_bank.sv */
// Summary of operation
// - field value is the binary priority level
// - level 000 disables the source
// - unused bits read zero, ignore writes
// - fields reset to level 4
// - fields read back the value written
// - register 0 holds serial2, irq2, timer5
// - register 1 holds can and spi2 levels
// - can sources stay off without can module
// - register 2 holds only dma3 at 2-0
// - register 3 holds dma4 and parallel port
// - register 4 holds encoder1 and pwm1
// - register 5 holds fault, calendar, dma5
//
// Decided for this implementation: the register offsets and the Wishbone slave port.
module ipb_priority_bank
	import ipb_pkg::*;
#(
	parameter bit CAN_PRESENT = 1'b1  // build without the can module: 0
)
(
	input  wire logic         core_clk,
	input  wire logic         rst,
	input  wire logic         wb_cyc_i,
	input  wire logic         wb_stb_i,
	input  wire logic         wb_we_i,
	input  wire logic [7:0]   wb_adr_i,
	input  wire logic [3:0]   wb_sel_i,
	input  wire logic [31:0]  wb_dat_i,
	output logic [31:0]       wb_dat_o,
	output logic              wb_ack_o,
	output ipb_level_type     serial2_transmit_level,
	output ipb_level_type     serial2_receive_level,
	output ipb_level_type     external_irq2_level,
	output ipb_level_type     timer5_level,
	output ipb_level_type     can_event_level,
	output ipb_level_type     can_receive_level,
	output ipb_level_type     spi_two_event_level,
	output ipb_level_type     spi_two_error_level,
	output ipb_level_type     dma_ch3_done_level,
	output ipb_level_type     dma_ch4_done_level,
	output ipb_level_type     parallel_port_level,
	output ipb_level_type     encoder1_level,
	output ipb_level_type     pulse_gen1_level,
	output ipb_level_type     pulse_fault_a_level,
	output ipb_level_type     calendar_clock_level,
	output ipb_level_type     dma_ch5_done_level,
	output logic [15:0]       sourceActive
);
	ipb_regbus_if    regBus ();                   // slave to bank link
	ipb_level_type   fieldStore [NUM_SOURCES];    // software-visible fields
	ipb_level_type   next_fieldStore [NUM_SOURCES];
	ipb_level_type   levelOut [NUM_SOURCES];      // levels to arbitration
	ipb_level_type   next_levelOut [NUM_SOURCES];
	logic [15:0]     next_sourceActive;           // nonzero-level mask

	// bus slave: decode, ack and read data capture
	ipb_wb_slave busSlave (
		.core_clk (core_clk),
		.rst      (rst),
		.wb_cyc_i (wb_cyc_i),
		.wb_stb_i (wb_stb_i),
		.wb_we_i  (wb_we_i),
		.wb_adr_i (wb_adr_i),
		.wb_sel_i (wb_sel_i),
		.wb_dat_i (wb_dat_i),
		.wb_dat_o (wb_dat_o),
		.wb_ack_o (wb_ack_o),
		.regBus   (regBus)
	);

	// is a source physically present in this build
	function automatic logic sourcePresent(input int src);
		sourcePresent = CAN_PRESENT
			|| (src != int'(SRC_CAN_EVENT) && src != int'(SRC_CAN_RECEIVE));
	endfunction

	// assemble one register image from the stored fields
	function automatic logic [REG_W-1:0] regImage(
		input logic [2:0]    idx,
		input ipb_level_type f [NUM_SOURCES]
	);
		logic [REG_W-1:0] img;
		img = 16'h0000;  // unused slots stay zero
		for (int s = 0; s < NUM_SOURCES; s++)
		begin
			if (SRC_REG[s] == idx)
				img[SRC_POS[s] +: LEVEL_W] = f[s];
		end
		regImage = img;
	endfunction

	// field update: a write touches only the slots mapped in the register
	// and only through the byte lane that carries the slot
	always_comb
	begin
		for (int s = 0; s < NUM_SOURCES; s++)
		begin
			next_fieldStore[s] = fieldStore[s];
			if (regBus.wrStrobe && regBus.regIndex == SRC_REG[s]
				&& regBus.wrLanes[SRC_POS[s][3]])
				next_fieldStore[s] = regBus.wrData[SRC_POS[s] +: LEVEL_W];
		end
	end

	// stored fields: level 4 out of reset
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			for (int s = 0; s < NUM_SOURCES; s++)
				fieldStore[s] <= FIELD_RESET;
		end
		else
		begin
			for (int s = 0; s < NUM_SOURCES; s++)
				fieldStore[s] <= next_fieldStore[s];
		end
	end

	// outgoing levels load from the next field value so a write reaches
	// the arbitration on the same edge it lands in the register
	always_comb
	begin
		next_sourceActive = 16'h0000;
		for (int s = 0; s < NUM_SOURCES; s++)
		begin
			// absent sources are forced off whatever software wrote
			if (sourcePresent(s))
				next_levelOut[s] = next_fieldStore[s];
			else
				next_levelOut[s] = LEVEL_OFF;
			// level zero means the source may never request
			next_sourceActive[s] = (next_levelOut[s] != LEVEL_OFF);
		end
	end

	// output flops toward the arbitration logic
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			for (int s = 0; s < NUM_SOURCES; s++)
				levelOut[s] <= FIELD_RESET;
			// an absent can module never shows a live level, not even
			// while reset is held, so the gate holds from the first edge
			if (!CAN_PRESENT)
			begin
				levelOut[int'(SRC_CAN_EVENT)]   <= LEVEL_OFF;
				levelOut[int'(SRC_CAN_RECEIVE)] <= LEVEL_OFF;
			end
		end
		else
		begin
			for (int s = 0; s < NUM_SOURCES; s++)
				levelOut[s] <= next_levelOut[s];
		end
	end

	// active mask flop; reset value mirrors the present sources
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			sourceActive <= CAN_PRESENT ? 16'hFFFF : 16'hFFCF;
		else
			sourceActive <= next_sourceActive;
	end

	// read image: fields, or the active mask in the status slot
	always_comb
	begin
		if (regBus.regIndex == REG_ACTIVE_STATUS)
			regBus.rdData = sourceActive;
		else
			regBus.rdData = regImage(regBus.regIndex, fieldStore);
	end

	// named outputs, each a plain alias of its flop
	assign serial2_transmit_level = levelOut[int'(SRC_SERIAL2_TX)];
	assign serial2_receive_level  = levelOut[int'(SRC_SERIAL2_RX)];
	assign external_irq2_level    = levelOut[int'(SRC_EXT_IRQ2)];
	assign timer5_level           = levelOut[int'(SRC_TIMER5)];
	assign can_event_level        = levelOut[int'(SRC_CAN_EVENT)];
	assign can_receive_level      = levelOut[int'(SRC_CAN_RECEIVE)];
	assign spi_two_event_level    = levelOut[int'(SRC_SPI2_EVENT)];
	assign spi_two_error_level    = levelOut[int'(SRC_SPI2_ERROR)];
	assign dma_ch3_done_level     = levelOut[int'(SRC_DMA3_DONE)];
	assign dma_ch4_done_level     = levelOut[int'(SRC_DMA4_DONE)];
	assign parallel_port_level    = levelOut[int'(SRC_PARALLEL_PORT)];
	assign encoder1_level         = levelOut[int'(SRC_ENCODER1)];
	assign pulse_gen1_level       = levelOut[int'(SRC_PULSE_GEN1)];
	assign pulse_fault_a_level    = levelOut[int'(SRC_PULSE_FAULT_A)];
	assign calendar_clock_level   = levelOut[int'(SRC_CALENDAR)];
	assign dma_ch5_done_level     = levelOut[int'(SRC_DMA5_DONE)];

	// timer5 level and stored calendar field read 4 right after reset release
	reset_levels_a: assert property (@(posedge core_clk)
		disable iff (rst)
		$past(rst) |-> (timer5_level == 3'h4
			&& fieldStore[int'(SRC_CALENDAR)] == 3'h4))
		else $error("level not 4 after reset");

	// serial2 transmit slot takes bits 14-12 as its binary level
	write_tx_a: assert property (@(posedge core_clk)
		disable iff (rst)
		(regBus.wrStrobe && regBus.regIndex == 3'h0 && regBus.wrLanes[1])
		|=> serial2_transmit_level == $past(regBus.wrData[14:12]))
		else $error("serial2 transmit level not written");

	// spi2 error slot takes bits 2-0 through lane 0
	write_spierr_a: assert property (@(posedge core_clk)
		disable iff (rst)
		(regBus.wrStrobe && regBus.regIndex == 3'h1 && regBus.wrLanes[0])
		|=> spi_two_error_level == $past(regBus.wrData[2:0]))
		else $error("spi2 error level not written");

	// can sources stay off in a build without can
	can_gate_a: assert property (@(posedge core_clk)
		disable iff (rst)
		!CAN_PRESENT |-> (can_event_level == 3'h0
			&& can_receive_level == 3'h0 && !sourceActive[4]))
		else $error("absent can source enabled");

	// dma3 register reads nothing above bit 2
	dma3_only_a: assert property (@(posedge core_clk)
		disable iff (rst)
		(regBus.regIndex == 3'h2) |-> regBus.rdData[15:3] == 13'h0000)
		else $error("dma3 register upper bits not zero");

	// dma4 slot takes bits 10-8, parallel port unchanged by lane 1 only
	write_dma4_a: assert property (@(posedge core_clk)
		disable iff (rst)
		(regBus.wrStrobe && regBus.regIndex == 3'h3 && regBus.wrLanes == 2'h2)
		|=> (dma_ch4_done_level == $past(regBus.wrData[10:8])
			&& $stable(parallel_port_level)))
		else $error("dma4 write wrong");

	// pwm1 slot takes bits 6-4
	write_pwm1_a: assert property (@(posedge core_clk)
		disable iff (rst)
		(regBus.wrStrobe && regBus.regIndex == 3'h4 && regBus.wrLanes[0])
		|=> pulse_gen1_level == $past(regBus.wrData[6:4]))
		else $error("pwm1 level not written");

	// calendar slot takes bits 10-8
	write_rtc_a: assert property (@(posedge core_clk)
		disable iff (rst)
		(regBus.wrStrobe && regBus.regIndex == 3'h5 && regBus.wrLanes[1])
		|=> calendar_clock_level == $past(regBus.wrData[10:8]))
		else $error("calendar level not written");

	// unused bits of the first register never read as one
	reserved_zero_a: assert property (@(posedge core_clk)
		disable iff (rst)
		(regBus.regIndex == 3'h0) |-> (regBus.rdData & 16'h8888) == 16'h0000)
		else $error("reserved bit reads one");

	// the serial2 transmit active flag never stands beside level zero
	disabled_flag_a: assert property (@(posedge core_clk)
		disable iff (rst)
		sourceActive[0] == (serial2_transmit_level != 3'h0))
		else $error("active flag disagrees with level");

	// a read answer carries the stored spi2 event field of register 1
	readback_a: assert property (@(posedge core_clk)
		disable iff (rst)
		(wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == 8'h04)
		##1 (wb_ack_o && !regBus.wrStrobe)
		|-> wb_dat_o[6:4] == fieldStore[int'(SRC_SPI2_EVENT)])
		else $error("read data differs from stored field");

	// timer5 and encoder1 levels hold steady while no write lands
	level_hold_a: assert property (@(posedge core_clk)
		disable iff (rst)
		!regBus.wrStrobe |=> $stable(timer5_level) && $stable(encoder1_level))
		else $error("level moved without a write");

	// timer5 slot takes bits 2-0 through lane 0
	write_timer5_a: assert property (@(posedge core_clk)
		disable iff (rst)
		(regBus.wrStrobe && regBus.regIndex == 3'h0 && regBus.wrLanes[0])
		|=> timer5_level == $past(regBus.wrData[2:0]))
		else $error("timer5 level not written");

	// a write on lane 0 alone leaves the serial2 receive slot alone
	lane_gate_a: assert property (@(posedge core_clk)
		disable iff (rst)
		(regBus.wrStrobe && regBus.regIndex == 3'h0 && regBus.wrLanes == 2'h1)
		|=> ($stable(serial2_receive_level)
			&& external_irq2_level == $past(regBus.wrData[6:4])))
		else $error("lane 0 write disturbed upper slots");

	// can event slot takes bits 14-12 where the can module is built
	write_canev_a: assert property (@(posedge core_clk)
		disable iff (rst)
		(CAN_PRESENT && regBus.wrStrobe && regBus.regIndex == 3'h1
			&& regBus.wrLanes[1])
		|=> can_event_level == $past(regBus.wrData[14:12]))
		else $error("can event level not written");

	// dma3 slot takes bits 2-0 through lane 0
	write_dma3_a: assert property (@(posedge core_clk)
		disable iff (rst)
		(regBus.wrStrobe && regBus.regIndex == 3'h2 && regBus.wrLanes[0])
		|=> dma_ch3_done_level == $past(regBus.wrData[2:0]))
		else $error("dma3 level not written");

	// fault slot takes bits 14-12 through lane 1
	write_fault_a: assert property (@(posedge core_clk)
		disable iff (rst)
		(regBus.wrStrobe && regBus.regIndex == 3'h5 && regBus.wrLanes[1])
		|=> pulse_fault_a_level == $past(regBus.wrData[14:12]))
		else $error("fault level not written");

	// unused bits of the sixth register never read as one
	reserved_last_a: assert property (@(posedge core_clk)
		disable iff (rst)
		(regBus.regIndex == 3'h5) |-> (regBus.rdData & 16'h888F) == 16'h0000)
		else $error("reserved bit of last register reads one");
endmodule

/* File: test/ipb_testbench.sv */
module testbench
	import ipb_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic           coreClk = 1'b0;          // 40 MHz bus clock
	logic           rst     = 1'b1;          // held for the first cycles
	logic           wbCyc   = 1'b0;
	logic           wbStb   = 1'b0;
	logic           wbWe    = 1'b0;
	logic [7:0]     wbAdr   = 8'h00;
	logic [3:0]     wbSel   = 4'h0;
	logic [31:0]    wbWdat  = 32'h0000_0000;
	logic [31:0]    wbRdat [2];              // build 0 with can, 1 without
	logic           wbAck [2];
	ipb_level_type  lvl [2][NUM_SOURCES];    // level outputs of each build
	logic [15:0]    act [2];                 // nonzero-level flags
	logic [15:0]    regImage [6];            // expected bank contents
	logic [31:0]    rnd = 32'h0000_ad10;     // lfsr state, fixed seed
	int             nErrors = 0;
	int             samplesChecked = 0;

	// slot of each source: register index and low bit, in output order
	localparam int regOf [NUM_SOURCES] = '{0,0,0,0,1,1,1,1,2,3,3,4,4,5,5,5};
	localparam int lowOf [NUM_SOURCES] = '{12,8,4,0,12,8,4,0,0,8,4,8,4,12,8,4};
	// implemented bits per register; the rest must read zero
	localparam logic [15:0] implMask [6] = '{16'h7777, 16'h7777, 16'h0007,
		16'h0770, 16'h0770, 16'h7770};
	localparam logic [7:0] ofsOf [6] = '{OFS_SERIAL2_TIMER5, OFS_CAN_SPI2,
		OFS_DMA3, OFS_DMA4_PARPORT, OFS_ENCODER_PWM, OFS_FAULT_RTC_DMA5};

	// free-running clock, half period 12.5 ns
	always #12.5 coreClk = ~coreClk;

	// both builds share the bus so their answers can be compared
	for (genvar g = 0; g < 2; g++)
	begin : bank
		ipb_priority_bank #(.CAN_PRESENT(g == 0)) ipb_priority_bank_i (
			.core_clk(coreClk), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
			.wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
			.wb_dat_i(wbWdat), .wb_dat_o(wbRdat[g]), .wb_ack_o(wbAck[g]),
			.serial2_transmit_level(lvl[g][0]), .serial2_receive_level(lvl[g][1]),
			.external_irq2_level(lvl[g][2]), .timer5_level(lvl[g][3]),
			.can_event_level(lvl[g][4]), .can_receive_level(lvl[g][5]),
			.spi_two_event_level(lvl[g][6]), .spi_two_error_level(lvl[g][7]),
			.dma_ch3_done_level(lvl[g][8]), .dma_ch4_done_level(lvl[g][9]),
			.parallel_port_level(lvl[g][10]), .encoder1_level(lvl[g][11]),
			.pulse_gen1_level(lvl[g][12]), .pulse_fault_a_level(lvl[g][13]),
			.calendar_clock_level(lvl[g][14]), .dma_ch5_done_level(lvl[g][15]),
			.sourceActive(act[g]));
	end

	// 32-bit galois-free shift register, taps 32 22 2 1
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// level build b should present for source s
	function automatic ipb_level_type exp_level(input int b, input int s);
		ipb_level_type v;
		v = ipb_level_type'(regImage[regOf[s]] >> lowOf[s]);
		// the build without can keeps both can sources off
		if (b == 1 && (s == 4 || s == 5))
			v = 3'h0;
		return v;
	endfunction

	// expected read word; unmapped places read zero
	function automatic logic [31:0] exp_read(input int b, input logic [7:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		for (int k = 0; k < 6; k++)
			if (ofsOf[k] == a)
				v = {16'h0000, regImage[k]};
		if (a == OFS_ACTIVE_STATUS)
			for (int s = 0; s < NUM_SOURCES; s++)
				v[s] = (exp_level(b, s) != 3'h0);
		return v;
	endfunction

	// single comparison point, counts and reports
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp)
		begin
			nErrors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	// the one place where the run ends
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", samplesChecked, nErrors);
		if (nErrors == 0 && samplesChecked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// classic cycle: hold everything until ack is sampled, then release
	task automatic bus(input logic we, input logic [7:0] a,
		input logic [3:0] sel, input logic [31:0] wd);
		int n;
		logic [15:0] lanes;
		@(posedge coreClk);
		check("ack idle", wbAck[0], 1'b0);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= a;
		wbSel <= sel;
		wbWdat <= wd;
		n = 0;
		// bounded wait; a lost ack ends the run
		while (wbAck[0] !== 1'b1)
		begin
			@(posedge coreClk);
			n++;
			if (n > 20)
			begin
				nErrors++;
				end_of_test();
			end
		end
		check("ack latency", n, 2);
		check("ack of second build", wbAck[1], 1'b1);
		if (!we)
			for (int b = 0; b < 2; b++)
				check("read data", wbRdat[b], exp_read(b, a));
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		// byte lanes gate the fields; unused bits never stick
		lanes = {{8{sel[1]}}, {8{sel[0]}}};
		for (int k = 0; k < 6; k++)
			if (we && ofsOf[k] == a)
				regImage[k] = (regImage[k] & ~lanes)
					| (wd[15:0] & implMask[k] & lanes);
	endtask

	// level outputs settle just after the edge that took the write
	task automatic check_outputs();
		logic [15:0] a;
		#1;
		for (int b = 0; b < 2; b++)
		begin
			a = 16'h0000;
			for (int s = 0; s < NUM_SOURCES; s++)
			begin
				check("level", lvl[b][s], exp_level(b, s));
				a[s] = (exp_level(b, s) != 3'h0);
			end
			check("source active", act[b], a);
		end
	endtask

	// power-on style reset, also used in mid-run
	task automatic reset_bank();
		@(posedge coreClk);
		rst <= 1'b1;
		for (int k = 0; k < 6; k++)
			regImage[k] = implMask[k] & 16'h4444;
		repeat (5) @(posedge coreClk);
		for (int b = 0; b < 2; b++)
			for (int s = 0; s < NUM_SOURCES; s++)
				check("reset level", lvl[b][s], exp_level(b, s));
		check("reset active", act[1], 16'hffcf);
		check("reset ack", wbAck[0], 1'b0);
		rst <= 1'b0;
	endtask

	// read every register back and compare the outputs
	task automatic read_all(input string name);
		for (int k = 0; k < 6; k++)
			bus(1'b0, ofsOf[k], 4'hf, 32'h0000_0000);
		bus(1'b0, OFS_ACTIVE_STATUS, 4'hf, 32'h0000_0000);
		check_outputs();
		$display("test %s done", name);
	endtask

	initial
	begin
		reset_bank();
		read_all("reset values");
		// every level pattern in every field, junk in the spare bits
		for (int l = 0; l < 8; l++)
		begin
			for (int k = 0; k < 6; k++)
			begin
				rnd = lfsr_next(rnd);
				bus(1'b1, ofsOf[k], 4'h3, {rnd[31:16],
					{4{1'b0, 3'(l)}} | (rnd[15:0] & 16'h8888)});
			end
			read_all("level sweep");
		end
		// unmapped, unaligned and status writes are ignored
		bus(1'b1, 8'h02, 4'hf, 32'hffff_ffff);
		bus(1'b1, OFS_ACTIVE_STATUS, 4'hf, 32'h0000_0000);
		bus(1'b0, 8'h02, 4'hf, 32'h0000_0000);
		bus(1'b0, 8'hfc, 4'hf, 32'h0000_0000);
		// single-lane writes touch only the slots of their own byte
		bus(1'b1, OFS_SERIAL2_TIMER5, 4'h1, 32'h0000_0777);
		bus(1'b1, OFS_DMA4_PARPORT, 4'h2, 32'h0000_0000);
		bus(1'b1, OFS_FAULT_RTC_DMA5, 4'h2, 32'h0000_6000);
		read_all("ignored places");
		// random traffic over all offsets, lanes and directions
		repeat (80)
		begin
			rnd = lfsr_next(rnd);
			wbAdr <= wbAdr;
			bus(rnd[5], (rnd[4:3] == 2'b11) ? rnd[15:8] : {3'b000, rnd[2:0],
				2'b00}, rnd[9:6], lfsr_next(rnd));
			check_outputs();
		end
		read_all("random traffic");
		// reset in mid-run returns every field to level 4
		reset_bank();
		read_all("second reset");
		end_of_test();
	end
endmodule
